/* muxed_byte_bus_host_port.sv */
// Host access port on a multiplexed address/data byte bus.
// Assumes strobes from an external bus master, asynchronous to ref_clk_i,
// and a register core that answers rd requests with rdata_i in the same cycle.
`timescale 1ns/1ps
module muxed_byte_bus_host_port
    import bus_port_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       bus_style_strap_i,
    input  wire logic       address_strobe_i,
    input  wire logic       data_strobe_i,
    input  wire logic       read_write_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic [7:0] shared_byte_lines_i,
    input  wire logic       power_fail_i,
    input  wire logic       osc_input_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] shared_byte_lines_o,
    output logic            shared_byte_lines_oe_n_o,
    output logic            osc_output_o,
    output logic            osc_tick_o,
    output logic            addr_valid_o,
    output access_t         access_o
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = 15;

    logic [SYNC_W-1:0] sync_vec;
    bus_pins_t         pins;
    logic              strap;
    logic              pfail;
    logic              osc_s;

    pin_sync #(.W(SYNC_W)) u_sync
    (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({address_strobe_i, data_strobe_i, read_write_i, chip_sel_n_i,
                     shared_byte_lines_i, bus_style_strap_i, power_fail_i,
                     osc_input_i}),
        .sync_o    (sync_vec)
    );

    assign pins  = bus_pins_t'(sync_vec[SYNC_W-1:3]);
    assign strap = sync_vec[2];
    assign pfail = sync_vec[1];
    assign osc_s = sync_vec[0];

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    bus_pins_t prev;
    logic      osc_prev;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            prev     <= '0;
            osc_prev <= 1'b0;
        end
        else
        begin
            prev     <= pins;
            osc_prev <= osc_s;
        end
    end

    logic as_fall;
    logic as_rise;
    logic ds_fall;
    logic ds_rise;
    logic rw_rise;
    logic mode_ds;
    logic selected;

    assign as_fall  = prev.address_strobe & ~pins.address_strobe;
    assign as_rise  = ~prev.address_strobe & pins.address_strobe;
    assign ds_fall  = prev.data_strobe & ~pins.data_strobe;
    assign ds_rise  = ~prev.data_strobe & pins.data_strobe;
    assign rw_rise  = ~prev.read_write & pins.read_write;
    assign mode_ds  = strap;
    assign selected = ~pins.chip_sel_n & ~pfail;

    // ------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------
    logic [7:0] addr;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            addr         <= ADDR_RST;
            addr_valid_o <= 1'b0;
        end
        else if (as_rise)
        begin
            addr_valid_o <= 1'b0;
        end
        else if (as_fall)
        begin
            addr         <= pins.shared_byte_lines;
            addr_valid_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read and write decode
    // ------------------------------------------------------------
    logic wr_evt;
    logic rd_start;
    logic rd_end;
    logic rd_window;
    port_phase_t phase;

    // In data-strobe mode, direction taken from the sample while the strobe was still high
    assign wr_evt   = mode_ds ? (ds_fall & ~prev.read_write) : rw_rise;
    assign rd_window = mode_ds ? (pins.data_strobe & pins.read_write)
                               : (~pins.data_strobe & pins.read_write);
    assign rd_start = rd_window & selected & addr_valid_o;
    assign rd_end   = mode_ds ? ds_fall : ds_rise;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            access_o <= '0;
        end
        else
        begin
            access_o.wr    <= wr_evt & selected & addr_valid_o;
            access_o.rd    <= 1'b0;
            access_o.addr  <= addr;
            access_o.wdata <= wr_evt ? prev.shared_byte_lines : WDATA_RST;
            if (rd_start && phase == PH_ADDR)
            begin
                access_o.rd <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read drive sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            phase <= PH_IDLE;
        end
        else
        begin
            unique case (phase)
                PH_IDLE:
                    if (as_fall)
                        phase <= PH_ADDR;
                PH_ADDR:
                    if (!addr_valid_o)
                        phase <= PH_IDLE;
                    else if (rd_start)
                        phase <= PH_READ;
                PH_READ:
                    if (rd_end || !selected)
                        phase <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            shared_byte_lines_o      <= RDATA_RST;
            shared_byte_lines_oe_n_o <= 1'b1;
        end
        else
        begin
            if (access_o.rd)
                shared_byte_lines_o <= rdata_i;
            shared_byte_lines_oe_n_o <= ~(phase == PH_READ && rd_window && !rd_end
                                          && selected);
        end
    end

    // ------------------------------------------------------------
    // Timekeeping oscillator
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            osc_output_o <= 1'b1;
            osc_tick_o   <= 1'b0;
        end
        else
        begin
            osc_output_o <= ~osc_s;
            osc_tick_o   <= osc_s & ~osc_prev;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_addr_capture;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        as_fall && !as_rise |=> addr == $past(pins.shared_byte_lines) && addr_valid_o;
    endproperty
    a_addr_capture: assert property (p_addr_capture)
        else $error("address not captured on strobe fall");

    property p_addr_discard;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        as_rise |=> !addr_valid_o;
    endproperty
    a_addr_discard: assert property (p_addr_discard)
        else $error("address kept after strobe rise");

    property p_no_unselected_write;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !$past(selected) |-> !access_o.wr;
    endproperty
    a_no_unselected_write: assert property (p_no_unselected_write)
        else $error("write without chip select");

    property p_pfail_blocks;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        pfail |=> !access_o.wr && !access_o.rd && shared_byte_lines_oe_n_o;
    endproperty
    a_pfail_blocks: assert property (p_pfail_blocks)
        else $error("access during power fail");

    property p_ds_write;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        mode_ds && ds_fall && !prev.read_write && selected && addr_valid_o
            |=> access_o.wr && access_o.wdata == $past(prev.shared_byte_lines);
    endproperty
    a_ds_write: assert property (p_ds_write)
        else $error("data-strobe write missed");

    property p_sep_write;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !mode_ds && rw_rise && selected && addr_valid_o |=> access_o.wr;
    endproperty
    a_sep_write: assert property (p_sep_write)
        else $error("separate-strobe write missed");

    property p_drive_only_in_window;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !shared_byte_lines_oe_n_o |-> $past(rd_window) && $past(selected);
    endproperty
    a_drive_only_in_window: assert property (p_drive_only_in_window)
        else $error("bus driven outside read window");

    property p_release;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        rd_end |=> shared_byte_lines_oe_n_o;
    endproperty
    a_release: assert property (p_release)
        else $error("bus not released at read end");

    property p_unselected_addr;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        as_fall && !selected |=> addr_valid_o;
    endproperty
    a_unselected_addr: assert property (p_unselected_addr)
        else $error("unselected address not latched");

    c_write: cover property (@(posedge ref_clk_i) access_o.wr);
    c_read:  cover property (@(posedge ref_clk_i) !shared_byte_lines_oe_n_o);
    c_pfail: cover property (@(posedge ref_clk_i) pfail && as_fall);
    c_sep:   cover property (@(posedge ref_clk_i) !mode_ds && rw_rise);
endmodule : muxed_byte_bus_host_port

/* bus_port_pkg.sv */
// Shared types and constants for the multiplexed byte bus port.
// Assumes a single 40 MHz system clock domain.
package bus_port_pkg;

    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned OSC_HZ       = 32768;
    localparam int unsigned REF_CLK_HZ   = 40000000;
    localparam logic [7:0]  ADDR_RST     = 8'h00;
    localparam logic [7:0]  RDATA_RST    = 8'h00;
    localparam logic [7:0]  WDATA_RST    = 8'h00;

    // Bus pins after synchronisation
    typedef struct packed {
        logic       address_strobe;
        logic       data_strobe;
        logic       read_write;
        logic       chip_sel_n;
        logic [7:0] shared_byte_lines;
    } bus_pins_t;

    // One register access request towards the register core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } access_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_READ
    } port_phase_t;

endpackage : bus_port_pkg

/* pin_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes pins are quasi-static across the two sampling edges.
`timescale 1ns/1ps
module pin_sync
    import bus_port_pkg::*;
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            stage1 <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : pin_sync

/* bus_master_model.sv */
// Behavioural processor bus master for the multiplexed byte bus port.
// Assumes the bench resolves the shared byte lines and calls its tasks.
`timescale 1ns/1ps
module bus_master_model
(
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] bus_i,
    output logic            strap_o,
    output logic            as_o,
    output logic            ds_o,
    output logic            rw_o,
    output logic            cs_n_o,
    output logic [7:0]      bus_o,
    output logic            bus_en_o
);
    initial
    begin
        strap_o  = 1'b0;
        as_o     = 1'b0;
        ds_o     = 1'b1;
        rw_o     = 1'b1;
        cs_n_o   = 1'b1;
        bus_o    = 8'h00;
        bus_en_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask : tick

    // Strobe first so idle level changes cannot look like a read
    task automatic set_mode(input logic m);
        as_o = 1'b1;
        tick(6);
        strap_o = m;
        ds_o = ~m;
        rw_o = 1'b1;
        tick(6);
    endtask : set_mode

    task automatic run_cycle(input logic wr, input logic sel_n, input logic [7:0] a,
                             input logic [7:0] d, output logic [7:0] q);
        cs_n_o = sel_n;
        bus_o = a;
        bus_en_o = 1'b1;
        as_o = 1'b1;
        tick(6);
        as_o = 1'b0;
        tick(6);
        bus_o = d;
        bus_en_o = wr;
        if (strap_o)
        begin
            rw_o = ~wr;
            tick(2);
            ds_o = 1'b1;
        end
        else if (wr)
            rw_o = 1'b0;
        else
            ds_o = 1'b0;
        tick(10);
        q = bus_i;
        ds_o = ~strap_o;
        rw_o = 1'b1;
        tick(6);
        bus_en_o = 1'b0;
        cs_n_o = 1'b1;
        tick(4);
    endtask : run_cycle
endmodule : bus_master_model

/* tb.sv */
// Self-checking bench for the multiplexed byte bus host port.
// Assumes bus_master_model drives the pins and the bench acts as register core.
`timescale 1ns/1ps
module tb;
    import bus_port_pkg::*;
    logic       ref_clk_i, sys_rst_i, power_fail_i, osc_input_i, osc_run;
    logic       m_strap, m_as, m_ds, m_rw, m_cs_n, m_en, oe_n, osc_out, osc_tick, addr_valid;
    logic [7:0] rdata_i, m_d, dev_d, bus_w, rd_q;
    logic [7:0] last_bus = 8'h00;
    access_t    acc, last_acc;
    int         bad_count = 0, cmp_count = 0, acc_n = 0, tick_n = 0, rise_n = 0, as_hi = 0;
    int         seed, r;

    // Released lines show a pattern that changes every cycle
    assign bus_w = m_en ? m_d : (oe_n === 1'b0 ? dev_d : ~last_bus);

    bus_master_model bfm (.ref_clk_i(ref_clk_i), .bus_i(bus_w), .strap_o(m_strap),
        .as_o(m_as), .ds_o(m_ds), .rw_o(m_rw), .cs_n_o(m_cs_n), .bus_o(m_d), .bus_en_o(m_en));

    muxed_byte_bus_host_port uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .bus_style_strap_i(m_strap), .address_strobe_i(m_as), .data_strobe_i(m_ds),
        .read_write_i(m_rw), .chip_sel_n_i(m_cs_n), .shared_byte_lines_i(bus_w),
        .power_fail_i(power_fail_i), .osc_input_i(osc_input_i), .rdata_i(rdata_i),
        .shared_byte_lines_o(dev_d), .shared_byte_lines_oe_n_o(oe_n),
        .osc_output_o(osc_out), .osc_tick_o(osc_tick), .addr_valid_o(addr_valid),
        .access_o(acc));

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'hA5;
    endfunction : exp_rd

    function automatic int will_access(input logic sel_n, input logic pf);
        return (!sel_n && !pf) ? 1 : 0;
    endfunction : will_access

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        last_bus <= bus_w;
        as_hi <= m_as ? as_hi + 1 : 0;
        if (acc.wr === 1'b1 || acc.rd === 1'b1)
        begin
            acc_n <= acc_n + 1;
            last_acc <= acc;
        end
        if (osc_tick === 1'b1)
            tick_n <= tick_n + 1;
        if (as_hi == 5)
            check(addr_valid === 1'b0, "address kept after strobe rise");
        #2 rdata_i = exp_rd(acc.addr);
    end

    initial
    begin
        wait (sys_rst_i === 1'b0);
        while (osc_run)
        begin
            repeat (610) @(posedge ref_clk_i);
            #2 osc_input_i = ~osc_input_i;
            rise_n += osc_input_i;
        end
    end

    task automatic do_cycle(input logic m, input logic wr, input logic sel_n, input logic pf,
                            input logic [7:0] a, input logic [7:0] d);
        int n0;
        int take;
        if (m_strap !== m)
            bfm.set_mode(m);
        power_fail_i = pf;
        n0 = acc_n;
        take = will_access(sel_n, pf);
        bfm.run_cycle(wr, sel_n, a, d, rd_q);
        power_fail_i = 1'b0;
        check(acc_n == n0 + take, "access count");
        check(addr_valid === 1'b1, "address not latched");
        check(oe_n === 1'b1, "bus not released");
        if (take == 1)
        begin
            check(last_acc.addr === a && last_acc.wr === wr && last_acc.rd === ~wr, "kind");
            if (wr)
                check(last_acc.wdata === d, "write data");
            else
                check(rd_q === exp_rd(a), "read data");
        end
    endtask : do_cycle

    initial
    begin
        seed = 32'h4820297f;
        sys_rst_i = 1'b1;
        power_fail_i = 1'b0;
        osc_input_i = 1'b0;
        osc_run = 1'b1;
        rdata_i = 8'h00;
        repeat (6) @(posedge ref_clk_i);
        #2 sys_rst_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #2;
        for (int k = 0; k < 16; k++)
            do_cycle(k[0], k[1], k[2], k[3], k[1] ? 8'hFF : 8'h00, k[0] ? 8'hFF : 8'h00);
        for (int k = 0; k < 40; k++)
        begin
            r = $random(seed);
            do_cycle(r[0], r[1], r[4] & r[5], r[6] & r[7], r[15:8], r[23:16]);
        end
        osc_run = 1'b0;
        repeat (1300) @(posedge ref_clk_i);
        check(tick_n == rise_n, "oscillator tick count");
        check(osc_out === ~osc_input_i, "oscillator output level");
        wrap_up();
    end

    initial
    begin
        #500000;
        bad_count++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule : tb
